// ===== rtl/aaa_annunciator.sv
// Behaviour
// - code flashes are 0.5 s on, 0.5 s off, 2.5 s pause between repeats
// - red flash count equals the fault family digit
// - yellow flash count equals the fault number digit
// - the common leading letter is never flashed
// - families A to F give ten to fifteen red flashes
// - configuration fault flashes every lamp together
// - lamp panel user fault blinks red and one corner lamp
// - display panel shows code, blinks yellow, beeps thrice per 20 s for the first five minutes
// - fault removal stops beeping and clears the shown code
// - faults shown while running; config and supply also at selection
// - door release needs low level, under 55 C, motor stopped
// - pre-release drain adds cooling water above 65 C
// - pre-release drain pumps until empty, at most three minutes
// - three newest fault codes kept and restored across power cycles
// - diagnostic position eleven shows the newest stored code
// - option touch steps to the next older stored code
// - run/pause touch returns to the newest stored code
// - leak-check and spin positions show drum rpm divided by ten
// - leak-check turns 55 rpm each way with 250 rpm pulses
// - heating test never heats above 80 C
// - both sensors held five seconds at position eleven erase history
`timescale 1ns/1ps
`default_nettype none
module aaa_annunciator #(
  parameter int TICK_CYC = aaa_pkg::TICK_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire aaa_pkg::aaa_apb_req_t apbIn,
  output var  aaa_pkg::aaa_apb_rsp_t apbRsp,
  input  wire aaa_pkg::aaa_sens_t    sens,
  input  wire logic [23:0]          nvmLoad,
  output var  logic [23:0]          nvmImage,
  output var  logic                 nvmSave,
  output var  aaa_pkg::aaa_lamp_t    lamps,
  output var  logic                 buzzer,
  output var  logic [11:0]          dispValue,
  output var  logic                 dispFault,
  output var  logic                 doorRelease,
  output var  logic                 coolFill,
  output var  logic                 drainPump,
  output var  logic                 heaterOn,
  output var  logic [7:0]           motorRpm,
  output var  logic                 motorCw
);
  import aaa_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    aaa_apb_rsp_t rsp;
    aaa_ctrl_t ctrl;
    aaa_fault_t flt;
    logic [2:0][7:0] hist;
    logic restored;
    logic nvmSave;
    logic [1:0] histIdx;
    logic [TICK_W-1:0] tickCnt;
    logic tick;
    logic blink;
    logic [11:0] blinkTmr;
    aaa_fl_t fl;
    logic [11:0] flTmr;
    logic [3:0] flCnt;
    aaa_lamp_t lamps;
    logic [11:0] beepPer;
    logic [11:0] beepWin;
    logic buzzer;
    logic [11:0] drainTmr;
    logic drainDone;
    logic [11:0] eraseTmr;
    logic prevRun;
    logic prevOpt;
    logic door;
    logic cool;
    logic pump;
    logic heater;
    logic [7:0] motRpm;
    logic motCw;
    logic [11:0] leakTmr;
    logic [1:0] leakPh;
    logic [11:0] disp;
    logic dispFault;
  } aaa_st_t;
  aaa_st_t s_q, s_d;
  logic        wr, mapped, faultShown, cfgShow, showHist, flashSeq;
  logic        runRise, optRise, preAct;
  logic [7:0]  codeSel;
  logic [3:0]  fam, num;
  logic [11:0] bphase;
  aaa_fault_t  newF;
  assign wr = apbIn.psel && apbIn.penable && s_q.rsp.pready && apbIn.pwrite;
  assign mapped = apbIn.paddr == A_CTRL || apbIn.paddr == A_FAULT ||
                  apbIn.paddr == A_STAT || apbIn.paddr == A_HIST;
  assign newF = aaa_fault_t'(apbIn.pwdata);
  assign faultShown = s_q.flt.active && (s_q.ctrl.progRun || s_q.ctrl.diag ||
    ((s_q.flt.cfgFlt || s_q.flt.supplyFlt) && s_q.ctrl.progSel));
  assign cfgShow = faultShown && s_q.flt.cfgFlt;
  assign showHist = s_q.ctrl.diag && s_q.ctrl.pos == POS_HIST;
  assign flashSeq = showHist && !s_q.ctrl.panelDisp && !cfgShow;
  assign codeSel = s_q.hist[s_q.histIdx];
  assign fam = codeSel[7:4];
  assign num = codeSel[3:0];
  assign runRise = sens.runTouch && !s_q.prevRun;
  assign optRise = sens.optTouch && !s_q.prevOpt && !sens.runTouch;
  assign preAct = faultShown && s_q.flt.preDrain && !s_q.drainDone;
  assign bphase = s_q.beepPer / T_BEEP;
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.nvmSave = 1'b0;
    // apb slave, one wait state
    s_d.rsp.pready = apbIn.psel && apbIn.penable && !s_q.rsp.pready;
    s_d.rsp.pslverr = s_d.rsp.pready && !mapped;
    s_d.rsp.prdata = '0;
    if (s_d.rsp.pready && !apbIn.pwrite) begin
      unique case (apbIn.paddr)
        A_CTRL:  s_d.rsp.prdata = s_q.ctrl;
        A_FAULT: s_d.rsp.prdata = s_q.flt;
        A_STAT:  s_d.rsp.prdata = aaa_stat_t'{rsv: '0, fl: s_q.fl,
                   histIdx: s_q.histIdx, drainDone: s_q.drainDone,
                   door: s_q.door, shown: faultShown,
                   buzzer: s_q.buzzer};
        A_HIST:  s_d.rsp.prdata = {8'h00, s_q.hist};
        default: s_d.rsp.prdata = '0;
      endcase
    end
    // tick and blink
    s_d.tick = s_q.tickCnt == TICK_W'(TICK_CYC - 1);
    s_d.tickCnt = s_d.tick ? '0 : s_q.tickCnt + 1'b1;
    if (s_q.tick) begin
      if (s_q.blinkTmr == T_FLASH - 12'h001) begin
        s_d.blinkTmr = '0;
        s_d.blink = !s_q.blink;
      end else begin
        s_d.blinkTmr = s_q.blinkTmr + 12'h001;
      end
    end
    // flash sequencer
    if (!flashSeq) begin
      s_d.fl = FL_IDLE;
      s_d.flTmr = '0;
    end else if (s_q.tick) begin
      if (s_q.fl != FL_IDLE && s_q.flTmr != '0) begin
        s_d.flTmr = s_q.flTmr - 12'h001;
      end else begin
        unique case (s_q.fl)
          FL_IDLE: begin
            if (fam != '0) begin
              s_d.fl = FL_RON;
              s_d.flCnt = fam;
              s_d.flTmr = T_FLASH - 12'h001;
            end else if (num != '0) begin
              s_d.fl = FL_YON;
              s_d.flCnt = num;
              s_d.flTmr = T_FLASH - 12'h001;
            end else begin
              s_d.fl = FL_PAUSE;
              s_d.flTmr = T_PAUSE - 12'h001;
            end
          end
          FL_RON: begin
            s_d.fl = FL_ROFF;
            s_d.flTmr = T_FLASH - 12'h001;
          end
          FL_ROFF: begin
            if (s_q.flCnt > 4'h1) begin
              s_d.fl = FL_RON;
              s_d.flCnt = s_q.flCnt - 4'h1;
              s_d.flTmr = T_FLASH - 12'h001;
            end else if (num != '0) begin
              s_d.fl = FL_YON;
              s_d.flCnt = num;
              s_d.flTmr = T_FLASH - 12'h001;
            end else begin
              s_d.fl = FL_PAUSE;
              s_d.flTmr = T_PAUSE - 12'h001;
            end
          end
          FL_YON: begin
            s_d.fl = FL_YOFF;
            s_d.flTmr = T_FLASH - 12'h001;
          end
          FL_YOFF: begin
            if (s_q.flCnt > 4'h1) begin
              s_d.fl = FL_YON;
              s_d.flCnt = s_q.flCnt - 4'h1;
              s_d.flTmr = T_FLASH - 12'h001;
            end else begin
              s_d.fl = FL_PAUSE;
              s_d.flTmr = T_PAUSE - 12'h001;
            end
          end
          FL_PAUSE: s_d.fl = FL_IDLE;
          default:  s_d.fl = FL_IDLE;
        endcase
      end
    end
    // lamps
    s_d.lamps = '0;
    if (cfgShow) begin
      s_d.lamps.red = s_q.blink;
      s_d.lamps.yellow = s_q.blink;
      s_d.lamps.corner = {CORNER_N{s_q.blink}};
      s_d.lamps.others = s_q.blink;
    end else if (faultShown && !s_q.ctrl.panelDisp && s_q.flt.userFlt) begin
      s_d.lamps.red = s_q.blink;
      s_d.lamps.corner[s_q.flt.corner] = s_q.blink;
    end else if (faultShown && s_q.ctrl.panelDisp) begin
      s_d.lamps.yellow = s_q.blink;
    end else if (flashSeq) begin
      s_d.lamps.red = s_q.fl == FL_RON;
      s_d.lamps.yellow = s_q.fl == FL_YON;
    end
    // beeps
    if (!(faultShown && s_q.ctrl.panelDisp)) begin
      s_d.beepPer = '0;
      s_d.beepWin = '0;
      s_d.buzzer = 1'b0;
    end else begin
      s_d.buzzer = s_q.beepWin < T_BWIN && s_q.beepPer < T_BSPAN &&
                   !bphase[0];
      if (s_q.tick && s_q.beepWin < T_BWIN) begin
        s_d.beepWin = s_q.beepWin + 12'h001;
        s_d.beepPer = (s_q.beepPer == T_BPER - 12'h001) ? '0 :
                      s_q.beepPer + 12'h001;
      end
    end
    // display
    s_d.dispFault = 1'b0;
    s_d.disp = '0;
    if (faultShown && s_q.ctrl.panelDisp) begin
      s_d.dispFault = 1'b1;
      s_d.disp = {DISP_E, s_q.flt.code};
    end else if (s_q.ctrl.diag && (s_q.ctrl.pos == POS_LEAK ||
                 s_q.ctrl.pos == POS_SPIN)) begin
      s_d.disp = sens.drumRpm / RPM_DIV;
    end else if (showHist && s_q.ctrl.panelDisp) begin
      s_d.disp = {DISP_E, codeSel};
    end
    // pre-release drain and door
    s_d.cool = preAct && sens.temp > TEMP_COOL;
    s_d.pump = preAct && sens.temp <= TEMP_COOL;
    if (!faultShown) begin
      s_d.drainDone = 1'b0;
      s_d.drainTmr = '0;
    end else if (s_q.pump) begin
      if (sens.levelEmpty || s_q.drainTmr == T_DRAIN - 12'h001) begin
        s_d.drainDone = 1'b1;
      end else if (s_q.tick) begin
        s_d.drainTmr = s_q.drainTmr + 12'h001;
      end
    end
    s_d.door = faultShown && sens.levelLow && sens.temp < TEMP_DOOR &&
               sens.motorStopped &&
               (!s_q.flt.preDrain || s_q.drainDone);
    // heating and leak check
    s_d.heater = s_q.ctrl.diag && s_q.ctrl.pos == POS_HEAT &&
                 s_q.ctrl.heatReq && sens.temp <= TEMP_HEAT;
    if (s_q.ctrl.diag && s_q.ctrl.pos == POS_LEAK) begin
      if (s_q.tick) begin
        if (s_q.leakTmr == T_LEAK - 12'h001) begin
          s_d.leakTmr = '0;
          s_d.leakPh = (s_q.leakPh == 2'h2) ? 2'h0 : s_q.leakPh + 2'h1;
        end else begin
          s_d.leakTmr = s_q.leakTmr + 12'h001;
        end
      end
      s_d.motRpm = (s_q.leakPh == 2'h2) ? PULSE_RPM : LEAK_RPM;
      s_d.motCw = s_q.leakPh != 2'h1;
    end else begin
      s_d.leakTmr = '0;
      s_d.leakPh = 2'h0;
      s_d.motRpm = '0;
      s_d.motCw = 1'b0;
    end
    // history
    s_d.prevRun = sens.runTouch;
    s_d.prevOpt = sens.optTouch;
    if (!s_q.restored) begin
      s_d.restored = 1'b1;
      s_d.hist = nvmLoad;
    end
    if (!showHist) begin
      s_d.histIdx = '0;
      s_d.eraseTmr = '0;
    end else begin
      if (runRise) begin
        s_d.histIdx = '0;
      end else if (optRise && s_q.histIdx != HIST_OLD) begin
        s_d.histIdx = s_q.histIdx + 2'h1;
      end
      if (!(sens.runTouch && sens.optTouch)) begin
        s_d.eraseTmr = '0;
      end else if (s_q.tick && s_q.eraseTmr != T_ERASE) begin
        s_d.eraseTmr = s_q.eraseTmr + 12'h001;
        if (s_d.eraseTmr == T_ERASE) begin
          s_d.hist = '0;
          s_d.histIdx = '0;
          s_d.nvmSave = 1'b1;
        end
      end
    end
    // register writes
    if (wr && apbIn.paddr == A_CTRL) begin
      s_d.ctrl = aaa_ctrl_t'(apbIn.pwdata);
      s_d.ctrl.rsv = '0;
    end
    if (wr && apbIn.paddr == A_FAULT) begin
      s_d.flt = newF;
      s_d.flt.rsv = '0;
      if (newF.active && !s_q.flt.active) begin
        s_d.hist = {s_q.hist[1:0], newF.code};
        s_d.histIdx = '0;
        s_d.nvmSave = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign apbRsp = s_q.rsp;
  assign nvmImage = s_q.hist;
  assign nvmSave = s_q.nvmSave;
  assign lamps = s_q.lamps;
  assign buzzer = s_q.buzzer;
  assign dispValue = s_q.disp;
  assign dispFault = s_q.dispFault;
  assign doorRelease = s_q.door;
  assign coolFill = s_q.cool;
  assign drainPump = s_q.pump;
  assign heaterOn = s_q.heater;
  assign motorRpm = s_q.motRpm;
  assign motorCw = s_q.motCw;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_door_gate: assert property (s_q.door |-> $past(sens.temp) < TEMP_DOOR
    && $past(sens.motorStopped) && $past(sens.levelLow))
    else $error("door released while unsafe");
  a_heat_limit: assert property (s_q.heater |->
    $past(sens.temp) <= TEMP_HEAT) else $error("heater on above limit");
  a_cool_fill: assert property (s_q.cool |->
    $past(sens.temp) > TEMP_COOL && !s_q.pump)
    else $error("cooling fill wrong");
  a_flash_len: assert property ($changed(s_q.fl) && (s_q.fl == FL_RON ||
    s_q.fl == FL_YON) |-> s_q.flTmr == T_FLASH - 12'h001)
    else $error("flash phase length wrong");
  a_pause_len: assert property ($changed(s_q.fl) && s_q.fl == FL_PAUSE
    |-> s_q.flTmr == T_PAUSE - 12'h001) else $error("pause length wrong");
  a_red_count: assert property ($past(s_q.fl) == FL_IDLE &&
    s_q.fl == FL_RON |-> s_q.flCnt == $past(fam))
    else $error("red count not family");
  a_beep_stop: assert property (!faultShown |=> !s_q.buzzer
    && s_q.disp[11:8] != DISP_E || s_q.ctrl.diag)
    else $error("beep after fault cleared");
  a_hist_push: assert property (wr && apbIn.paddr == A_FAULT &&
    newF.active && !s_q.flt.active && s_q.restored |=>
    s_q.hist[0] == $past(newF.code) && s_q.nvmSave)
    else $error("fault not recorded");
  a_hist_back: assert property (showHist && runRise |=>
    s_q.histIdx == 2'h0) else $error("run touch did not return");
  a_err_unmap: assert property (s_q.rsp.pready |-> s_q.rsp.pslverr ==
    !$past(mapped)) else $error("unmapped access answer wrong");
endmodule
`default_nettype wire

// ===== rtl/aaa_pkg.sv
`default_nettype none
package aaa_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ   = 50_000_000;
  localparam int TICK_MS  = 100;
  localparam int TICK_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W   = 24;
  localparam int FLASH_MS = 500;
  localparam int PAUSE_MS = 2500;
  localparam int BEEP_MS  = 100;
  localparam int BEEP_N   = 3;
  localparam int BPER_MS  = 20_000;
  localparam int BWIN_MS  = 300_000;
  localparam int DRAIN_MS = 180_000;
  localparam int ERASE_MS = 5000;
  localparam int LEAK_MS  = 10_000;
  localparam logic [11:0] T_FLASH = 12'(FLASH_MS / TICK_MS);
  localparam logic [11:0] T_PAUSE = 12'(PAUSE_MS / TICK_MS);
  localparam logic [11:0] T_BEEP  = 12'(BEEP_MS / TICK_MS);
  localparam logic [11:0] T_BSPAN = 12'(2 * BEEP_N * BEEP_MS / TICK_MS);
  localparam logic [11:0] T_BPER  = 12'(BPER_MS / TICK_MS);
  localparam logic [11:0] T_BWIN  = 12'(BWIN_MS / TICK_MS);
  localparam logic [11:0] T_DRAIN = 12'(DRAIN_MS / TICK_MS);
  localparam logic [11:0] T_ERASE = 12'(ERASE_MS / TICK_MS);
  localparam logic [11:0] T_LEAK  = 12'(LEAK_MS / TICK_MS);
  // ****************************************
  // limits and positions
  // ****************************************
  localparam logic [7:0]  TEMP_DOOR = 8'h37;
  localparam logic [7:0]  TEMP_COOL = 8'h41;
  localparam logic [7:0]  TEMP_HEAT = 8'h50;
  localparam logic [7:0]  LEAK_RPM  = 8'h37;
  localparam logic [7:0]  PULSE_RPM = 8'hFA;
  localparam logic [11:0] RPM_DIV   = 12'h00A;
  localparam logic [3:0]  POS_HEAT  = 4'h7;
  localparam logic [3:0]  POS_LEAK  = 4'h8;
  localparam logic [3:0]  POS_SPIN  = 4'h9;
  localparam logic [3:0]  POS_HIST  = 4'hB;
  localparam logic [3:0]  DISP_E    = 4'hE;
  localparam logic [1:0]  HIST_OLD  = 2'h2;
  localparam int          CORNER_N  = 3;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_FAULT = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_HIST  = 8'h0C;
  typedef enum logic [2:0] {
    FL_IDLE  = 3'b000,
    FL_RON   = 3'b001,
    FL_ROFF  = 3'b010,
    FL_YON   = 3'b011,
    FL_YOFF  = 3'b100,
    FL_PAUSE = 3'b101
  } aaa_fl_t;
  typedef struct packed {
    logic [22:0] rsv;
    logic heatReq;
    logic progSel;
    logic progRun;
    logic diag;
    logic panelDisp;
    logic [3:0] pos;
  } aaa_ctrl_t;
  typedef struct packed {
    logic [16:0] rsv;
    logic [1:0] corner;
    logic preDrain;
    logic userFlt;
    logic supplyFlt;
    logic cfgFlt;
    logic active;
    logic [7:0] code;
  } aaa_fault_t;
  typedef struct packed {
    logic [22:0] rsv;
    aaa_fl_t fl;
    logic [1:0] histIdx;
    logic drainDone;
    logic door;
    logic shown;
    logic buzzer;
  } aaa_stat_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aaa_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } aaa_apb_rsp_t;
  typedef struct packed {
    logic runTouch;
    logic optTouch;
    logic levelLow;
    logic levelEmpty;
    logic motorStopped;
    logic [7:0] temp;
    logic [11:0] drumRpm;
  } aaa_sens_t;
  typedef struct packed {
    logic red;
    logic yellow;
    logic [CORNER_N-1:0] corner;
    logic others;
  } aaa_lamp_t;
endpackage
`default_nettype wire

// ===== verification/aaa_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module aaa_panel_model (
  input  wire logic               clk,
  input  wire aaa_pkg::aaa_lamp_t lamps,
  input  wire logic               pressRun,
  input  wire logic               pressOpt,
  output logic                    runTouch,
  output logic                    optTouch,
  output logic [4:0]              redN,
  output logic [4:0]              yelN,
  output logic [15:0]             onLen
);
  import aaa_pkg::*;
  // ****************************************
  // fingers on sensors, eye on lamps
  // ****************************************
  logic [4:0]  rc;
  logic [4:0]  yc;
  logic [15:0] hc;
  logic        rp;
  logic        yp;
  logic        ys;
  initial begin
    {runTouch, optTouch, redN, yelN, onLen} = '0;
    {rc, yc, hc, rp, yp, ys} = '0;
  end
  always @(posedge clk) begin
    // finger held exactly as long as commanded
    runTouch <= pressRun;
    optTouch <= pressOpt;
    rp <= lamps.red;
    yp <= lamps.yellow;
    if (lamps.red) begin
      hc <= hc + 16'h0001;
    end
    if (rp && !lamps.red) begin
      onLen <= hc;
      hc <= '0;
    end
    // a red start after yellow closes one sequence
    if (lamps.red && !rp) begin
      if (ys) begin
        redN <= rc;
        yelN <= yc;
        rc <= 5'h01;
        yc <= '0;
        ys <= 1'b0;
      end else begin
        rc <= rc + 5'h01;
      end
    end
    if (lamps.yellow && !yp) begin
      yc <= yc + 5'h01;
      ys <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/appliance_alarm_annunciator_test.sv
`timescale 1ns/1ps
`default_nettype none
module appliance_alarm_annunciator_test;
  import aaa_pkg::*;
  localparam int TC = 4;
  typedef struct {
    string       nm;
    logic [31:0] v;
    logic [31:0] m;
    logic        e;
  } aaa_exp_t;
  logic         clk;
  logic         resetn;
  aaa_apb_req_t req;
  aaa_apb_rsp_t rsp;
  aaa_sens_t    sens;
  aaa_lamp_t    lamps;
  logic [23:0]  nvmLoad;
  logic [23:0]  hist;
  logic [11:0]  disp;
  logic [11:0]  rpm;
  logic [7:0]   temp;
  logic         lvl;
  logic         stp;
  logic         pressRun;
  logic         pressOpt;
  logic         runT;
  logic         optT;
  logic [4:0]   redN;
  logic [4:0]   yelN;
  logic [15:0]  onLen;
  logic [23:0]  img;
  logic [7:0]   mrpm;
  logic         buzz;
  logic         dflt;
  logic         door;
  logic         cool;
  logic         pump;
  logic         heat;
  logic         mcw;
  logic         lvlE;
  aaa_exp_t     q[$];
  int           err_count;
  int           tests_run;
  int           cyc;
  assign sens = '{runTouch: runT, optTouch: optT, levelLow: lvl,
                  levelEmpty: lvlE, motorStopped: stp, temp: temp,
                  drumRpm: rpm};
  aaa_annunciator #(.TICK_CYC(TC)) u_dut (
    .clk(clk), .resetn(resetn), .apbIn(req), .apbRsp(rsp), .sens(sens),
    .nvmLoad(nvmLoad), .nvmImage(img), .nvmSave(), .lamps(lamps),
    .buzzer(buzz), .dispValue(disp), .dispFault(dflt),
    .doorRelease(door), .coolFill(cool), .drainPump(pump),
    .heaterOn(heat), .motorRpm(mrpm), .motorCw(mcw)
  );
  aaa_panel_model u_panel (
    .clk(clk), .lamps(lamps), .pressRun(pressRun), .pressOpt(pressOpt),
    .runTouch(runT), .optTouch(optT), .redN(redN), .yelN(yelN),
    .onLen(onLen)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] v, m, input logic e);
    q.push_back('{nm, v, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic press(input logic r, o, input int n);
    pressRun <= r;
    pressOpt <= o;
    tick(n);
    pressRun <= 1'b0;
    pressOpt <= 1'b0;
    tick(2);
  endtask
  task automatic record(input logic [7:0] code);
    apb(1'b1, A_FAULT, 32'h0);
    apb(1'b1, A_FAULT, 32'h100 | 32'(code));
    hist = {hist[15:0], code};
    rd("history", A_HIST, 32'(hist), 32'hFFFFFF, 1'b0);
    check("image", 32'(img), 32'(hist));
  endtask
  task automatic flash(input logic [7:0] code);
    record(code);
    tick(1400);
    check("red count", 32'(redN), 32'(code[7:4]));
    check("yellow count", 32'(yelN), 32'(code[3:0]));
    check("on length", 32'(onLen), 32'(T_FLASH) * TC);
  endtask
  // ****************************************
  // watcher
  // ****************************************
  always @(posedge clk) begin
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && q.size() > 0) begin
      aaa_exp_t e;
      e = q.pop_front();
      check(e.nm, rsp.prdata & e.m, e.v);
      check({e.nm, " error"}, 32'(rsp.pslverr), 32'(e.e));
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(90390));
    {err_count, tests_run, cyc} = '0;
    req = '0;
    {rpm, temp, lvl, stp, lvlE, pressRun, pressOpt} = '0;
    nvmLoad = 24'($urandom);
    hist = nvmLoad;
    resetn = 1'b0;
    tick(8);
    resetn <= 1'b1;
    rd("history", A_HIST, 32'(hist), 32'hFFFFFF, 1'b0);
    rd("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test restore done");
    apb(1'b1, A_CTRL, 32'h02B);
    flash(8'h43);
    flash(8'hA1);
    $display("test flash done");
    press(1'b0, 1'b1, 2);
    rd("older", A_STAT, 32'h10, 32'h30, 1'b0);
    press(1'b1, 1'b0, 2);
    rd("newest", A_STAT, 32'h00, 32'h30, 1'b0);
    $display("test browse done");
    lvl <= 1'b1;
    stp <= 1'b1;
    temp <= 8'($urandom_range(0, 54));
    tick(4);
    rd("door open", A_STAT, 32'h4, 32'h4, 1'b0);
    check("door pin", 32'(door), 32'h1);
    temp <= TEMP_DOOR;
    tick(4);
    rd("door hot", A_STAT, 32'h0, 32'h4, 1'b0);
    $display("test door done");
    apb(1'b1, A_CTRL, 32'h029);
    rpm <= 12'($urandom_range(0, 4095));
    tick(10);
    check("speed", 32'(disp), 32'(rpm / 12'h00A));
    $display("test speed done");
    apb(1'b1, A_CTRL, 32'h050);
    repeat (20) begin
      if (buzz !== 1'b1) begin
        tick(1);
      end
    end
    check("beep", 32'(buzz), 32'h1);
    check("fault code", 32'(disp), 32'hEA1);
    check("fault flag", 32'(dflt), 32'h1);
    apb(1'b1, A_FAULT, 32'h0);
    tick(3);
    check("beep off", 32'(buzz), 32'h0);
    check("code gone", 32'(disp), 32'h0);
    $display("test beep done");
    apb(1'b1, A_CTRL, 32'h040);
    temp <= TEMP_COOL + 8'h01;
    apb(1'b1, A_FAULT, 32'h1100);
    tick(3);
    check("cool fill", 32'(cool), 32'h1);
    check("drain early", 32'(pump), 32'h0);
    temp <= 8'h00;
    tick(3);
    check("drain on", 32'(pump), 32'h1);
    lvlE <= 1'b1;
    tick(3);
    check("drain stop", 32'(pump), 32'h0);
    rd("drained", A_STAT, 32'h8, 32'h8, 1'b0);
    lvlE <= 1'b0;
    apb(1'b1, A_FAULT, 32'h0);
    $display("test drain done");
    apb(1'b1, A_CTRL, 32'h127);
    tick(3);
    check("heater on", 32'(heat), 32'h1);
    temp <= TEMP_HEAT + 8'h01;
    tick(3);
    check("heater off", 32'(heat), 32'h0);
    apb(1'b1, A_CTRL, 32'h028);
    tick(3);
    check("leak speed", 32'(mrpm), 32'(LEAK_RPM));
    check("leak dir", 32'(mcw), 32'h1);
    $display("test heat done");
    apb(1'b1, A_CTRL, 32'h080);
    apb(1'b1, A_FAULT, 32'h0);
    apb(1'b1, A_FAULT, 32'h300);
    repeat (200) begin
      if (lamps.red !== 1'b1) begin
        tick(1);
      end
    end
    check("all lamps", 32'(lamps), 32'h3F);
    $display("test config done");
    apb(1'b1, A_CTRL, 32'h02B);
    press(1'b1, 1'b1, int'(T_ERASE) * TC + 20);
    rd("erased", A_HIST, 32'h0, 32'hFFFFFF, 1'b0);
    $display("test erase done");
    tick(4);
    summarize();
  end
endmodule
`default_nettype wire
